// *** core/peq_ctrl.v ***
`include "peq_defines.vh"
`timescale 1ns/100ps
`default_nettype none

// Multi-push FIFO of event codes; requests are pushed in slot order
module peq_queue #(
	parameter DEPTH = 4,
	parameter AW    = 2,
	parameter NSRC  = 4
) (
	// Clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// Push side
	input  wire [NSRC-1:0]  req,
	input  wire [NSRC*5-1:0] codes,
	output reg              ovf,
	// Pop side
	input  wire             pop,
	output wire [4:0]       head,
	output wire             nonempty
);
	localparam [AW:0] DEPTH_W = DEPTH;

	reg [4:0]        mem_reg [0:DEPTH-1];
	reg [AW-1:0]     wp_reg;
	reg [AW-1:0]     rp_reg;
	reg [AW:0]       cnt_reg;
	reg [AW:0]       nreq;
	reg [AW:0]       free;
	reg [AW:0]       acc;
	reg [AW:0]       k;
	reg [NSRC-1:0]   take;
	reg [NSRC*AW-1:0] slot;
	integer          i;
	integer          j;

	assign head     = mem_reg[rp_reg];
	assign nonempty = (cnt_reg != {(AW+1){1'b0}});

	always @* begin
		nreq = {(AW+1){1'b0}};
		ovf  = 1'b0;
		for (i = 0; i < NSRC; i = i + 1) begin
			if (req[i]) begin
				if (nreq == DEPTH_W - cnt_reg)
					ovf = 1'b1;
				else
					nreq = nreq + 1'b1;
			end
		end
		// Pop frees its slot only next cycle, so full is judged on the old count
		free = DEPTH_W - cnt_reg;
		acc  = (nreq > free) ? free : nreq;
		// Slot of each accepted request, in slot order
		k    = {(AW+1){1'b0}};
		take = {NSRC{1'b0}};
		slot = {(NSRC*AW){1'b0}};
		for (i = 0; i < NSRC; i = i + 1) begin
			if (req[i] && k < acc) begin
				take[i]          = 1'b1;
				slot[i*AW +: AW] = wp_reg + k[AW-1:0];
				k                = k + 1'b1;
			end
		end
	end

	always @(posedge pclk) begin
		for (j = 0; j < NSRC; j = j + 1) begin
			if (take[j])
				mem_reg[slot[j*AW +: AW]] <= codes[j*5 +: 5];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_reg  <= {AW{1'b0}};
			rp_reg  <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			wp_reg  <= wp_reg + acc[AW-1:0];
			rp_reg  <= rp_reg + {{(AW-1){1'b0}}, pop};
			cnt_reg <= cnt_reg + acc - {{AW{1'b0}}, pop};
		end
	end
endmodule

module peq_ctrl (
	// APB slave
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Event sources, one-cycle pulses on pclk
	input  wire [26:0] ev_pulse,
	// Handler side
	input  wire        hdl_done,
	output reg         hdl_start,
	output reg         hdl_active,
	output reg  [4:0]  hdl_event,
	// Interrupt
	output reg         irq
);
	reg  [26:0] attach_reg;
	reg  [2:0]  ovf_reg;
	reg  [2:0]  ovf_next;
	reg         gie_reg;
	reg  [2:0]  istat_reg;
	reg  [2:0]  istat_next;
	reg  [2:0]  imask_reg;
	reg  [26:0] attach_next;
	reg         refuse;
	reg  [2:0]  pop;
	reg         go;
	reg  [4:0]  pick;
	reg  [31:0] rd_next;
	reg         rd_err;

	wire [26:0] ev_ok = ev_pulse & attach_reg;
	wire        acc_wr = psel & penable & pready & pwrite;
	wire        acc_ph = psel & penable & ~pready;
	wire [2:0]  ovf_set;
	wire [2:0]  ne;
	wire [4:0]  head_c;
	wire [4:0]  head_i;
	wire [4:0]  head_t;

	// Slot order gives in-group rank; same-cycle events go by slot, not by event number
	wire [`PEQ_N_COMM-1:0] comm_req = {ev_ok[26], ev_ok[25], ev_ok[24], ev_ok[23],
		ev_ok[9], ev_ok[8]};
	wire [`PEQ_N_IO-1:0] io_req = {ev_ok[20:13], ev_ok[7], ev_ok[5], ev_ok[3], ev_ok[1],
		ev_ok[6], ev_ok[4], ev_ok[2], ev_ok[12], ev_ok[0]};
	wire [`PEQ_N_TIMED-1:0] timed_req = {ev_ok[22], ev_ok[21], ev_ok[11],
		ev_ok[10]};

	peq_queue #(.DEPTH(`PEQ_DEPTH_COMM), .AW(`PEQ_AW_COMM), .NSRC(`PEQ_N_COMM)) u_comm (
		.pclk     (pclk),
		.presetn  (presetn),
		.req      (comm_req),
		.codes    (`PEQ_COMM_CODES),
		.ovf      (ovf_set[`PEQ_OVF_COMM]),
		.pop      (pop[0]),
		.head     (head_c),
		.nonempty (ne[0])
	);

	peq_queue #(.DEPTH(`PEQ_DEPTH_IO), .AW(`PEQ_AW_IO), .NSRC(`PEQ_N_IO)) u_io (
		.pclk     (pclk),
		.presetn  (presetn),
		.req      (io_req),
		.codes    (`PEQ_IO_CODES),
		.ovf      (ovf_set[`PEQ_OVF_IO]),
		.pop      (pop[1]),
		.head     (head_i),
		.nonempty (ne[1])
	);

	peq_queue #(.DEPTH(`PEQ_DEPTH_TIMED), .AW(`PEQ_AW_TIMED), .NSRC(`PEQ_N_TIMED)) u_timed (
		.pclk     (pclk),
		.presetn  (presetn),
		.req      (timed_req),
		.codes    (`PEQ_TIMED_CODES),
		.ovf      (ovf_set[`PEQ_OVF_TIMED]),
		.pop      (pop[2]),
		.head     (head_t),
		.nonempty (ne[2])
	);

	// Dispatch only from idle, so a running handler is never displaced
	always @* begin
		go   = gie_reg & ~hdl_active & (|ne);
		pop  = 3'h0;
		pick = head_t;
		if (ne[0]) begin
			pick = head_c;
			pop  = {2'h0, go};
		end else if (ne[1]) begin
			pick = head_i;
			pop  = {1'h0, go, 1'h0};
		end else begin
			pop  = {go, 2'h0};
		end
	end

	// Attach write with 12 / 0,1 exclusion; the side already attached wins
	always @* begin
		attach_next = pwdata[26:0];
		refuse      = 1'b0;
		if (attach_next[`PEQ_EV_FC0_MATCH] &&
		    (attach_next[`PEQ_EV_EDGE0_RISE] || attach_next[`PEQ_EV_EDGE0_FALL])) begin
			refuse = 1'b1;
			if (attach_reg[`PEQ_EV_FC0_MATCH] && !attach_reg[`PEQ_EV_EDGE0_RISE] &&
			    !attach_reg[`PEQ_EV_EDGE0_FALL]) begin
				attach_next[`PEQ_EV_EDGE0_RISE] = 1'b0;
				attach_next[`PEQ_EV_EDGE0_FALL] = 1'b0;
			end else begin
				attach_next[`PEQ_EV_FC0_MATCH] = 1'b0;
			end
		end
	end

	// Set wins over clear for every sticky flag
	always @* begin
		ovf_next = ovf_reg;
		if (hdl_active && hdl_done && !(|ne))
			ovf_next = 3'h0;
		ovf_next = ovf_next | ovf_set;
		istat_next = istat_reg;
		if (acc_wr && paddr == `PEQ_OFF_ISTAT)
			istat_next = istat_reg & ~pwdata[2:0];
		istat_next[`PEQ_IRQ_OVF]    = istat_next[`PEQ_IRQ_OVF] | (|ovf_set);
		istat_next[`PEQ_IRQ_REFUSE] = istat_next[`PEQ_IRQ_REFUSE] |
			(acc_wr && paddr == `PEQ_OFF_ATTACH && refuse);
		istat_next[`PEQ_IRQ_DISP]   = istat_next[`PEQ_IRQ_DISP] | go;
	end

	always @* begin
		rd_next = 32'h00000000;
		rd_err  = 1'b0;
		if (paddr == `PEQ_OFF_ATTACH)
			rd_next[26:0] = attach_reg;
		else if (paddr == `PEQ_OFF_OVF)
			rd_next[2:0] = ovf_reg;
		else if (paddr == `PEQ_OFF_CTRL)
			rd_next[`PEQ_CTRL_GIE] = gie_reg;
		else if (paddr == `PEQ_OFF_HDL) begin
			rd_next[4:0] = hdl_event;
			rd_next[`PEQ_HDL_ACTIVE] = hdl_active;
			rd_next[`PEQ_HDL_PEND_LSB +: 3] = ne;
		end else if (paddr == `PEQ_OFF_ISTAT)
			rd_next[2:0] = istat_reg;
		else if (paddr == `PEQ_OFF_IMASK)
			rd_next[2:0] = imask_reg;
		else
			rd_err = 1'b1;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata     <= 32'h00000000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			attach_reg <= `PEQ_RST_ATTACH;
			gie_reg    <= `PEQ_RST_CTRL;
			imask_reg  <= `PEQ_RST_IMASK;
			istat_reg  <= 3'h0;
			ovf_reg    <= 3'h0;
			hdl_start  <= 1'b0;
			hdl_active <= 1'b0;
			hdl_event  <= 5'h00;
			irq        <= 1'b0;
		end else begin
			// One wait state: data and error are registered on the same edge that raises pready
			pready  <= acc_ph;
			prdata  <= acc_ph ? rd_next : 32'h00000000;
			pslverr <= acc_ph & rd_err;
			if (acc_wr) begin
				if (paddr == `PEQ_OFF_ATTACH)
					attach_reg <= attach_next;
				else if (paddr == `PEQ_OFF_CTRL)
					gie_reg <= pwdata[`PEQ_CTRL_GIE];
				else if (paddr == `PEQ_OFF_IMASK)
					imask_reg <= pwdata[2:0];
			end
			istat_reg <= istat_next;
			ovf_reg   <= ovf_next;
			irq       <= |(istat_next & imask_reg);
			hdl_start <= go;
			if (go) begin
				hdl_active <= 1'b1;
				hdl_event  <= pick;
			end else if (hdl_done) begin
				hdl_active <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// *** core/peq_defines.vh ***
`ifndef PEQ_DEFINES_VH
`define PEQ_DEFINES_VH

// Register byte offsets
`define PEQ_OFF_ATTACH   8'h00
`define PEQ_OFF_OVF      8'h04
`define PEQ_OFF_CTRL     8'h08
`define PEQ_OFF_HDL      8'h0C
`define PEQ_OFF_ISTAT    8'h10
`define PEQ_OFF_IMASK    8'h14

// Field positions
`define PEQ_OVF_COMM     0
`define PEQ_OVF_IO       1
`define PEQ_OVF_TIMED    2
`define PEQ_CTRL_GIE     0
`define PEQ_HDL_ACTIVE   8
`define PEQ_HDL_PEND_LSB 16
`define PEQ_IRQ_OVF      0
`define PEQ_IRQ_REFUSE   1
`define PEQ_IRQ_DISP     2

// Reset values
`define PEQ_RST_ATTACH   27'h0000000
`define PEQ_RST_CTRL     1'h0
`define PEQ_RST_IMASK    3'h0

// Event count, and event numbers with special handling
`define PEQ_EV_COUNT     27
`define PEQ_EV_EDGE0_RISE 0
`define PEQ_EV_EDGE0_FALL 1
`define PEQ_EV_FC0_MATCH 12

// Queue depths (largest variant)
`define PEQ_DEPTH_COMM   8
`define PEQ_AW_COMM      3
`define PEQ_DEPTH_IO     16
`define PEQ_AW_IO        4
`define PEQ_DEPTH_TIMED  8
`define PEQ_AW_TIMED     3

// Event codes per group, lowest slot pushes first
`define PEQ_COMM_CODES  {5'h1A, 5'h19, 5'h18, 5'h17, 5'h09, 5'h08}
`define PEQ_IO_CODES    {5'h14, 5'h13, 5'h12, 5'h11, 5'h10, 5'h0F, 5'h0E, 5'h0D, \
                         5'h07, 5'h05, 5'h03, 5'h01, 5'h06, 5'h04, 5'h02, 5'h0C, 5'h00}
`define PEQ_TIMED_CODES {5'h16, 5'h15, 5'h0B, 5'h0A}
`define PEQ_N_COMM       6
`define PEQ_N_IO         17
`define PEQ_N_TIMED      4

`endif

// *** test/peq_props_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module peq_props (
	// Bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Events and handler
	input wire logic [26:0] ev_pulse,
	input wire logic        hdl_done,
	input wire logic        hdl_start,
	input wire logic        hdl_active,
	input wire logic [4:0]  hdl_event,
	input wire logic        irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_run;
		hdl_active && !hdl_done;
	endsequence
	sequence s_idle;
		!hdl_active && !hdl_start;
	endsequence
	a_start_pulse: assert property (hdl_start |=> !hdl_start)
		else $error("start too long");
	a_start_active: assert property (hdl_start |-> hdl_active && hdl_event < 5'h1B)
		else $error("start without handler");
	a_rise_start: assert property ($rose(hdl_active) |-> hdl_start)
		else $error("handler without start");
	a_no_preempt: assert property (s_run |=> hdl_active && !hdl_start)
		else $error("handler pre-empted");
	a_event_hold: assert property (s_run |=> $stable(hdl_event))
		else $error("event changed mid handler");
	a_done_gap: assert property (hdl_active && hdl_done |=> s_idle)
		else $error("handler not ended");
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("wrong wait states");
	a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error outside answer");
endmodule
bind peq_ctrl peq_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .ev_pulse, .hdl_done, .hdl_start, .hdl_active,
	.hdl_event, .irq);
`default_nettype wire

// *** test/peq_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module peq_cpu_model (
	// Clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// Handler handshake
	input wire logic       hdl_start,
	input wire logic [4:0] hdl_event,
	input wire logic [3:0] lat,
	output logic           hdl_done
);
	logic [4:0] seen[$];
	logic [3:0] cnt;
	// Done only after a start, lat cycles later
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'h0;
			hdl_done <= 1'b0;
		end else begin
			hdl_done <= (cnt == 4'h1);
			if (hdl_start) begin
				seen.push_back(hdl_event);
				cnt <= lat;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "peq_defines.vh"
module tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic        pready, pslverr, hdl_done, hdl_start, hdl_active, irq;
	logic [26:0] ev_pulse = 27'h0;
	logic [4:0]  hdl_event;
	logic [3:0]  lat = 4'h2;
	int          num_errors = 0;
	int          tests_run = 0;
	int          i;
	logic [4:0]  exp_ord [26] = '{5'h08, 5'h09, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h00, 5'h02,
		5'h04, 5'h06, 5'h01, 5'h03, 5'h05, 5'h07, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12,
		5'h13, 5'h14, 5'h0A, 5'h0B, 5'h15, 5'h16};
	always #5 pclk = ~pclk;
	peq_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ev_pulse, .hdl_done, .hdl_start, .hdl_active, .hdl_event, .irq);
	peq_cpu_model cpu (.pclk, .presetn, .hdl_start, .hdl_event, .lat, .hdl_done);
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		chk({31'h0, pslverr}, {31'h0, err});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Level held n cycles counts as n events
	task pulse(input logic [26:0] m, input int n);
		@(posedge pclk);
		ev_pulse <= m;
		repeat (n) @(posedge pclk);
		ev_pulse <= 27'h0;
	endtask
	task wait_n(input int n);
		repeat (3000) if (cpu.seen.size() < n) @(posedge pclk);
	endtask
	task complete_run;
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#200000;
		num_errors++;
		complete_run();
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, `PEQ_OFF_IMASK, 32'h2, 1'b0);
		apb(1'b1, `PEQ_OFF_ATTACH, 32'h07FFEFFF, 1'b0);
		apb(1'b1, `PEQ_OFF_ATTACH, 32'h07FFFFFF, 1'b0);
		apb(1'b0, `PEQ_OFF_ATTACH, 32'h0, 1'b0);
		chk(rdat, 32'h07FFEFFF);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, `PEQ_OFF_ISTAT, 32'h7, 1'b0);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, 8'h20, 32'h0, 1'b1);
		chk(rdat, 32'h0);
		// All but event 12 at once, dispatch still off
		pulse(27'h07FFEFFF, 1);
		apb(1'b1, `PEQ_OFF_CTRL, 32'h1, 1'b0);
		wait_n(26);
		for (i = 0; i < 26; i++)
			chk({27'h0, cpu.seen[i]}, {27'h0, exp_ord[i]});
		apb(1'b1, `PEQ_OFF_CTRL, 32'h0, 1'b0);
		lat <= 4'h9;
		pulse(27'h00000500, 9);
		apb(1'b0, `PEQ_OFF_OVF, 32'h0, 1'b0);
		chk(rdat, 32'h5);
		apb(1'b1, `PEQ_OFF_CTRL, 32'h1, 1'b0);
		wait_n(42);
		repeat (12) @(posedge pclk);
		for (i = 0; i < 16; i++)
			chk({27'h0, cpu.seen[26 + i]}, (i < 8) ? 32'h8 : 32'hA);
		apb(1'b0, `PEQ_OFF_OVF, 32'h0, 1'b0);
		chk(rdat, 32'h0);
		apb(1'b1, `PEQ_OFF_ATTACH, 32'h1000, 1'b0);
		apb(1'b1, `PEQ_OFF_ATTACH, 32'h1003, 1'b0);
		apb(1'b0, `PEQ_OFF_ATTACH, 32'h0, 1'b0);
		chk(rdat, 32'h1000);
		apb(1'b1, `PEQ_OFF_ATTACH, 32'h0, 1'b0);
		pulse(27'h07FFFFFF, 1);
		repeat (8) @(posedge pclk);
		chk(cpu.seen.size(), 42);
		apb(1'b0, `PEQ_OFF_HDL, 32'h0, 1'b0);
		chk(rdat, 32'h0000000A);
		complete_run();
	end
endmodule
`default_nettype wire
